// ### fcps_pkg.sv
// Shared constants and types for the command parameter interpreter
package fcps_pkg;
  // Clock and delay time base
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned DELAY_UNIT_NS = 1000000;
  localparam int unsigned DELAY_UNIT_CYC = DELAY_UNIT_NS / CLK_PERIOD_NS;
  // Configuration defaults after reset
  localparam logic FIFO_EN_LOW_RST = 1'b1;
  localparam logic [3:0] FIFO_THR_RST = 4'h0;
  localparam logic [7:0] PRECOMP_TRK_RST = 8'h00;
  localparam logic LOCK_RST = 1'b0;
  localparam logic SEEK_EN_RST = 1'b0;
  localparam logic [6:0] HLOAD_RST = 7'h01;
  localparam logic [3:0] HUNLOAD_RST = 4'h1;
  // Sector size
  localparam logic [14:0] SECT_BASE_LEN = 15'h0080;
  localparam logic [2:0] SECT_CODE_MAX = 3'h7;
  // Gap 2 lengths
  localparam logic [7:0] GAP2_STD_LEN = 8'h16;
  localparam logic [7:0] GAP2_PERP_LEN = 8'h29;
  // Head numbers and first sector number
  localparam logic HEAD_FIRST = 1'b0;
  localparam logic HEAD_LAST = 1'b1;
  localparam logic [7:0] FIRST_SECTOR = 8'h01;
  // Sequencer states
  typedef enum logic [3:0] {
    FCPS_IDLE = 4'b0001,
    FCPS_SEEK = 4'b0010,
    FCPS_LOAD = 4'b0100,
    FCPS_XFER = 4'b1000
  } fcps_state_t;
endpackage

// ### fcps_core.sv
// Floppy command parameter interpreter and execution sequencer
// How it works
// R1: Implied seek enable set: seek before read/write with cylinder; clear: none.
// R2: End of track is the last sector number of the current track.
// R3: Perpendicular mode gap parameter changes written and expected gap 2.
// R4: Gap length parameter is gap 3 size between sectors.
// R5: Head select is 0 or 1 and is matched against the ID head.
// R6: After head load, wait head load delay before read or write.
// R7: Head unload delay runs from end of execution, then head unloads; code starts it only after read/write, a loaded head stays loaded after a seek.
// R8: Lock keeps FIFO enable, threshold, precomp track over soft reset.
// R9: Density bit one gives MFM, zero gives FM.
// R10: Multi-track treats head 0 then head 1 as one long track.
// R11: Multi-track: after last sector on head 0, continue head 1 sector 1.
// R12: Nonzero size code gives 128 shifted left by code, up to 07.
// R13: Size code 00 means 128-byte sector with short byte count.
// R14: Size code zero takes bytes per sector from short byte count.
// R15: Host must not pick sizes the drive cannot support; unchecked.
// R16: Seek uses the target cylinder as head destination.
// R17: FIFO enable is active low; default after reset is off.
// R18: All command parameters are captured and held during execution.
`timescale 1ns/100ps
`default_nettype none
module fcps_core import fcps_pkg::*; #(
  parameter int unsigned UNIT_CYC = DELAY_UNIT_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic soft_reset,
  // Command phase parameters
  input wire logic cmd_start,
  input wire logic cmd_rw,
  input wire logic cmd_seek,
  input wire logic multi_track_flag,
  input wire logic mfm_select,
  input wire logic head_side_select,
  input wire logic [7:0] cylinder,
  input wire logic [7:0] start_sector,
  input wire logic [2:0] sector_size_code,
  input wire logic [7:0] end_of_track_sector,
  input wire logic [7:0] inter_sector_gap_size,
  input wire logic [7:0] short_sector_byte_count,
  input wire logic [7:0] target_cylinder,
  // Specify, configure, lock and perpendicular settings
  input wire logic spec_write,
  input wire logic [6:0] head_load_delay,
  input wire logic [3:0] head_unload_delay,
  input wire logic cfg_write,
  input wire logic implied_seek_enable,
  input wire logic fifo_enable_low,
  input wire logic [3:0] fifo_threshold,
  input wire logic [7:0] precomp_start_track,
  input wire logic lock_write,
  input wire logic lock_value,
  input wire logic perp_write,
  input wire logic perp_gap_select,
  // Drive and data path events
  input wire logic seek_done,
  input wire logic sector_done,
  input wire logic id_valid,
  input wire logic id_head,
  // Drive and data path controls
  output logic busy_r,
  output logic seek_req_r,
  output logic [7:0] seek_cyl_r,
  output logic head_load_r,
  output logic head_sel_r,
  output logic [7:0] sector_r,
  output logic xfer_active_r,
  output logic exec_done_r,
  output logic [14:0] sector_len_r,
  output logic [14:0] xfer_bytes_r,
  output logic [7:0] gap3_len_r,
  output logic [7:0] gap2_len_r,
  output logic mfm_mode_r,
  output logic head_match_r,
  // Configuration state
  output logic fifo_enable_low_r,
  output logic [3:0] fifo_threshold_r,
  output logic [7:0] precomp_track_r,
  output logic lock_r
);

  // Sector length from size code
  function automatic logic [14:0] sect_len(input logic [2:0] code);
    sect_len = SECT_BASE_LEN << code;
  endfunction

  // Bytes moved per sector
  function automatic logic [14:0] sect_bytes(input logic [2:0] code,
                                             input logic [7:0] short_cnt);
    sect_bytes = (code == 3'h0) ? {7'h00, short_cnt} : // [R13] [R14]
                 sect_len(code); // [R12]
  endfunction

  // Configuration group
  logic seek_en_r, seek_en_nxt;
  logic [6:0] hload_r, hload_nxt;
  logic [3:0] hunload_r, hunload_nxt;
  logic perp_gap_r, perp_gap_nxt;
  logic fifo_enable_low_nxt, lock_nxt;
  logic [3:0] fifo_threshold_nxt;
  logic [7:0] precomp_track_nxt;
  always_comb begin
    seek_en_nxt = seek_en_r;
    hload_nxt = hload_r;
    hunload_nxt = hunload_r;
    perp_gap_nxt = perp_gap_r;
    fifo_enable_low_nxt = fifo_enable_low_r;
    fifo_threshold_nxt = fifo_threshold_r;
    precomp_track_nxt = precomp_track_r;
    lock_nxt = lock_r;
    if (soft_reset && !lock_r) begin
      fifo_enable_low_nxt = FIFO_EN_LOW_RST; // [R8] [R17]
      fifo_threshold_nxt = FIFO_THR_RST; // [R8]
      precomp_track_nxt = PRECOMP_TRK_RST; // [R8]
    end else if (cfg_write) begin
      fifo_enable_low_nxt = fifo_enable_low; // [R17]
      fifo_threshold_nxt = fifo_threshold;
      precomp_track_nxt = precomp_start_track;
    end
    if (cfg_write) begin
      seek_en_nxt = implied_seek_enable;
    end
    if (spec_write) begin
      hload_nxt = head_load_delay;
      hunload_nxt = head_unload_delay;
    end
    if (perp_write) begin
      perp_gap_nxt = perp_gap_select;
    end
    if (lock_write) begin
      lock_nxt = lock_value;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seek_en_r <= SEEK_EN_RST;
      hload_r <= HLOAD_RST;
      hunload_r <= HUNLOAD_RST;
      perp_gap_r <= 1'b0;
      fifo_enable_low_r <= FIFO_EN_LOW_RST; // [R17]
      fifo_threshold_r <= FIFO_THR_RST;
      precomp_track_r <= PRECOMP_TRK_RST;
      lock_r <= LOCK_RST;
    end else begin
      seek_en_r <= seek_en_nxt;
      hload_r <= hload_nxt;
      hunload_r <= hunload_nxt;
      perp_gap_r <= perp_gap_nxt;
      fifo_enable_low_r <= fifo_enable_low_nxt;
      fifo_threshold_r <= fifo_threshold_nxt;
      precomp_track_r <= precomp_track_nxt;
      lock_r <= lock_nxt;
    end
  end

  // Delay unit divider
  logic [31:0] div_r, div_nxt;
  logic tick_r, tick_nxt;
  always_comb begin
    tick_nxt = (div_r >= UNIT_CYC - 1);
    div_nxt = tick_nxt ? 32'h0 : div_r + 32'h1;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_r <= 32'h0;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  // Sequencer group
  fcps_state_t state_r, state_nxt;
  logic multi_r, multi_nxt, rw_r, rw_nxt;
  logic [7:0] last_sect_r, last_sect_nxt;
  logic [6:0] load_cnt_r, load_cnt_nxt;
  logic [3:0] unl_cnt_r, unl_cnt_nxt;
  logic unl_run_r, unl_run_nxt;
  logic busy_nxt, seek_req_nxt, head_load_nxt, head_sel_nxt;
  logic [7:0] seek_cyl_nxt, sector_nxt, gap3_len_nxt, gap2_len_nxt;
  logic xfer_active_nxt, exec_done_nxt, mfm_mode_nxt, head_match_nxt;
  logic [14:0] sector_len_nxt, xfer_bytes_nxt;
  always_comb begin
    state_nxt = state_r;
    multi_nxt = multi_r;
    rw_nxt = rw_r;
    last_sect_nxt = last_sect_r;
    load_cnt_nxt = load_cnt_r;
    unl_cnt_nxt = unl_cnt_r;
    unl_run_nxt = unl_run_r;
    seek_req_nxt = seek_req_r;
    seek_cyl_nxt = seek_cyl_r;
    head_load_nxt = head_load_r;
    head_sel_nxt = head_sel_r;
    sector_nxt = sector_r;
    gap3_len_nxt = gap3_len_r;
    gap2_len_nxt = perp_gap_r ? GAP2_PERP_LEN : GAP2_STD_LEN; // [R3]
    mfm_mode_nxt = mfm_mode_r;
    sector_len_nxt = sector_len_r;
    xfer_bytes_nxt = xfer_bytes_r;
    head_match_nxt = head_match_r;
    exec_done_nxt = 1'b0;
    if (id_valid) begin
      head_match_nxt = (id_head == head_sel_r); // [R5]
    end
    // Unload timer counts only while idle with the head loaded
    if (unl_run_r && tick_r) begin
      if (unl_cnt_r <= 4'h1) begin
        unl_run_nxt = 1'b0;
        head_load_nxt = 1'b0; // [R7]
      end else begin
        unl_cnt_nxt = unl_cnt_r - 4'h1;
      end
    end
    unique case (state_r)
      FCPS_IDLE: begin
        if (cmd_start && (cmd_rw || cmd_seek)) begin
          multi_nxt = multi_track_flag; // [R18] [R10]
          rw_nxt = cmd_rw;
          last_sect_nxt = end_of_track_sector; // [R2]
          head_sel_nxt = head_side_select; // [R5]
          sector_nxt = start_sector;
          gap3_len_nxt = inter_sector_gap_size; // [R4]
          mfm_mode_nxt = mfm_select; // [R9]
          sector_len_nxt = sect_len(sector_size_code); // [R12] [R13]
          xfer_bytes_nxt = sect_bytes(sector_size_code,
                                      short_sector_byte_count);
          unl_run_nxt = 1'b0;
          head_load_nxt = head_load_r; // [R7]
          if (cmd_seek) begin
            seek_cyl_nxt = target_cylinder; // [R16]
            seek_req_nxt = 1'b1;
            state_nxt = FCPS_SEEK;
          end else if (seek_en_r) begin
            seek_cyl_nxt = cylinder; // [R1]
            seek_req_nxt = 1'b1;
            state_nxt = FCPS_SEEK;
          end else begin
            load_cnt_nxt = hload_r;
            state_nxt = head_load_r ? FCPS_XFER : FCPS_LOAD; // [R1]
          end
        end
      end
      FCPS_SEEK: begin
        if (seek_done) begin
          seek_req_nxt = 1'b0;
          load_cnt_nxt = hload_r;
          if (!rw_r) begin
            exec_done_nxt = 1'b1;
            state_nxt = FCPS_IDLE;
          end else begin
            state_nxt = head_load_r ? FCPS_XFER : FCPS_LOAD;
          end
        end
      end
      FCPS_LOAD: begin
        head_load_nxt = 1'b1;
        if (load_cnt_r == 7'h00) begin
          state_nxt = FCPS_XFER; // [R6]
        end else if (tick_r) begin
          load_cnt_nxt = load_cnt_r - 7'h01; // [R6]
        end
      end
      FCPS_XFER: begin
        if (sector_done) begin
          if (sector_r != last_sect_r) begin
            sector_nxt = sector_r + 8'h01; // [R2]
          end else if (multi_r && head_sel_r == HEAD_FIRST) begin
            head_sel_nxt = HEAD_LAST; // [R11] [R10]
            sector_nxt = FIRST_SECTOR; // [R11]
          end else begin
            exec_done_nxt = 1'b1;
            unl_cnt_nxt = hunload_r; // [R7]
            unl_run_nxt = 1'b1; // [R7]
            state_nxt = FCPS_IDLE;
          end
        end
      end
      default: begin
        state_nxt = FCPS_IDLE;
      end
    endcase
    busy_nxt = (state_nxt != FCPS_IDLE);
    xfer_active_nxt = (state_nxt == FCPS_XFER);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= FCPS_IDLE;
      multi_r <= 1'b0;
      rw_r <= 1'b0;
      last_sect_r <= 8'h00;
      load_cnt_r <= 7'h00;
      unl_cnt_r <= 4'h0;
      unl_run_r <= 1'b0;
      busy_r <= 1'b0;
      seek_req_r <= 1'b0;
      seek_cyl_r <= 8'h00;
      head_load_r <= 1'b0;
      head_sel_r <= HEAD_FIRST;
      sector_r <= 8'h00;
      xfer_active_r <= 1'b0;
      exec_done_r <= 1'b0;
      sector_len_r <= SECT_BASE_LEN;
      xfer_bytes_r <= 15'h0000;
      gap3_len_r <= 8'h00;
      gap2_len_r <= GAP2_STD_LEN;
      mfm_mode_r <= 1'b0;
      head_match_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      multi_r <= multi_nxt;
      rw_r <= rw_nxt;
      last_sect_r <= last_sect_nxt;
      load_cnt_r <= load_cnt_nxt;
      unl_cnt_r <= unl_cnt_nxt;
      unl_run_r <= unl_run_nxt;
      busy_r <= busy_nxt;
      seek_req_r <= seek_req_nxt;
      seek_cyl_r <= seek_cyl_nxt;
      head_load_r <= head_load_nxt;
      head_sel_r <= head_sel_nxt;
      sector_r <= sector_nxt;
      xfer_active_r <= xfer_active_nxt;
      exec_done_r <= exec_done_nxt;
      sector_len_r <= sector_len_nxt;
      xfer_bytes_r <= xfer_bytes_nxt;
      gap3_len_r <= gap3_len_nxt;
      gap2_len_r <= gap2_len_nxt;
      mfm_mode_r <= mfm_mode_nxt;
      head_match_r <= head_match_nxt;
    end
  end
endmodule
`default_nettype wire

// ### fcps_properties.sv
// Port checks for the command parameter interpreter
`timescale 1ns/100ps
`default_nettype none
module fcps_properties import fcps_pkg::*; (
  // Clock and resets
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic soft_reset,
  // Command and configuration
  input wire logic cmd_start,
  input wire logic cmd_rw,
  input wire logic cmd_seek,
  input wire logic multi_track_flag,
  input wire logic mfm_select,
  input wire logic [7:0] cylinder,
  input wire logic [2:0] sector_size_code,
  input wire logic [7:0] end_of_track_sector,
  input wire logic [7:0] inter_sector_gap_size,
  input wire logic [7:0] short_sector_byte_count,
  input wire logic [7:0] target_cylinder,
  input wire logic cfg_write,
  input wire logic implied_seek_enable,
  input wire logic sector_done,
  // Outputs
  input wire logic busy_r,
  input wire logic seek_req_r,
  input wire logic [7:0] seek_cyl_r,
  input wire logic head_sel_r,
  input wire logic [7:0] sector_r,
  input wire logic xfer_active_r,
  input wire logic [14:0] sector_len_r,
  input wire logic [14:0] xfer_bytes_r,
  input wire logic [7:0] gap3_len_r,
  input wire logic mfm_mode_r,
  input wire logic fifo_enable_low_r,
  input wire logic [3:0] fifo_threshold_r,
  input wire logic [7:0] precomp_track_r,
  input wire logic lock_r
);
  logic go_rw, go_sk, ise_r, ise_nxt, multi_r, multi_nxt;
  logic [7:0] last_sect_r, last_sect_nxt;
  assign go_rw = cmd_start && cmd_rw && !cmd_seek && !busy_r;
  assign go_sk = cmd_start && cmd_seek && !busy_r;
  always_comb begin
    ise_nxt = cfg_write ? implied_seek_enable : ise_r;
    multi_nxt = go_rw ? multi_track_flag : multi_r;
    last_sect_nxt = go_rw ? end_of_track_sector : last_sect_r;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ise_r <= SEEK_EN_RST;
      multi_r <= 1'b0;
      last_sect_r <= 8'h00;
    end else begin
      ise_r <= ise_nxt;
      multi_r <= multi_nxt;
      last_sect_r <= last_sect_nxt;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence s_turn;
    xfer_active_r && sector_done && sector_r == last_sect_r
      ##0 multi_r && !head_sel_r;
  endsequence
  a_seek_target: assert property (
    go_sk |=> seek_req_r && seek_cyl_r == $past(target_cylinder))
    else $error("seek target");
  a_implied_seek: assert property (
    go_rw |=> seek_req_r == $past(ise_r)
      && (!seek_req_r || seek_cyl_r == $past(cylinder)))
    else $error("implied seek");
  a_size_code: assert property (
    go_rw |=> sector_len_r == SECT_BASE_LEN << $past(sector_size_code))
    else $error("sector length");
  a_short_count: assert property (
    go_rw |=> xfer_bytes_r == ($past(sector_size_code) == 3'h0 ?
      {7'h00, $past(short_sector_byte_count)} :
      SECT_BASE_LEN << $past(sector_size_code)))
    else $error("byte count");
  a_rw_fields: assert property (
    go_rw |=> gap3_len_r == $past(inter_sector_gap_size)
      && mfm_mode_r == $past(mfm_select))
    else $error("gap or density");
  a_param_hold: assert property (
    busy_r && $past(busy_r) |->
      $stable({gap3_len_r, sector_len_r, xfer_bytes_r, mfm_mode_r}))
    else $error("params moved");
  a_soft_reset: assert property (
    soft_reset && (!lock_r || !cfg_write) |=> ($past(lock_r) ?
      $stable({fifo_enable_low_r, fifo_threshold_r, precomp_track_r}) :
      {fifo_enable_low_r, fifo_threshold_r, precomp_track_r} ==
      {FIFO_EN_LOW_RST, FIFO_THR_RST, PRECOMP_TRK_RST}))
    else $error("soft reset");
  a_sector_step: assert property (
    xfer_active_r && sector_done && sector_r != last_sect_r |=>
      sector_r == $past(sector_r) + 8'h01 && xfer_active_r)
    else $error("sector step");
  a_head_turn: assert property (
    s_turn |=> head_sel_r && sector_r == FIRST_SECTOR && xfer_active_r)
    else $error("head turn");
endmodule
bind fcps_core fcps_properties u_chk (.*);
`default_nettype wire

// ### fcps_drive_model.sv
// Drive model answering seeks, sector IDs and sector ends
`timescale 1ns/100ps
`default_nettype none
module fcps_drive_model import fcps_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Pace and requests
  input wire logic [3:0] lat,
  input wire logic id_flip,
  input wire logic seek_req_r,
  input wire logic xfer_active_r,
  input wire logic head_sel_r,
  // Drive events
  output logic seek_done,
  output logic sector_done,
  output logic id_valid,
  output logic id_head
);
  logic [3:0] cnt_r, cnt_nxt;
  logic act, sk_nxt, sd_nxt, iv_nxt, ih_nxt;
  always_comb begin
    act = (seek_req_r || xfer_active_r) && !seek_done && !sector_done;
    cnt_nxt = act ? cnt_r + 4'h1 : 4'h0;
    sk_nxt = act && seek_req_r && cnt_r == lat;
    sd_nxt = act && !seek_req_r && cnt_r == lat;
    iv_nxt = act && !seek_req_r && cnt_r == 4'h0;
    ih_nxt = iv_nxt ? head_sel_r ^ id_flip : !head_sel_r;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_r <= 4'h0;
      {seek_done, sector_done, id_valid, id_head} <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
      {seek_done, sector_done} <= {sk_nxt, sd_nxt};
      {id_valid, id_head} <= {iv_nxt, ih_nxt};
    end
  end
endmodule
`default_nettype wire

// ### tb.sv
// Directed bench for the command parameter interpreter
`timescale 1ns/100ps
`default_nettype none
module tb import fcps_pkg::*; ();
  localparam int U = 4;
  logic clk_sys, rst, soft_reset, cmd_start, cmd_rw, cmd_seek, spec_write;
  logic multi_track_flag, mfm_select, head_side_select, cfg_write;
  logic implied_seek_enable, fifo_enable_low, lock_write, lock_value;
  logic perp_write, perp_gap_select, seek_done, sector_done, id_valid;
  logic id_head, busy_r, seek_req_r, head_load_r, head_sel_r, lock_r;
  logic xfer_active_r, exec_done_r, mfm_mode_r, head_match_r;
  logic fifo_enable_low_r, id_flip;
  logic [7:0] cylinder, start_sector, end_of_track_sector, target_cylinder;
  logic [7:0] inter_sector_gap_size, short_sector_byte_count, sector_r;
  logic [7:0] precomp_start_track, seek_cyl_r, gap3_len_r, gap2_len_r;
  logic [7:0] precomp_track_r;
  logic [2:0] sector_size_code;
  logic [6:0] head_load_delay;
  logic [3:0] head_unload_delay, fifo_threshold, fifo_threshold_r, lat;
  logic [14:0] sector_len_r, xfer_bytes_r;
  int num_errors, n_compared, n_sect, hl, xf;
  fcps_core #(.UNIT_CYC(U)) u_dut (.*);
  fcps_drive_model u_drv (.*);
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [14:0] seen, input logic [14:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d, wrong %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cfg(input logic ise);
    implied_seek_enable = ise;
    cfg_write = 1'b1;
    tick(1);
    cfg_write = 1'b0;
  endtask
  task automatic sreset();
    soft_reset = 1'b1;
    tick(1);
    soft_reset = 1'b0;
    tick(1);
  endtask
  task automatic run(input logic sk, input logic [2:0] n,
                     input logic [7:0] e, input logic multi);
    {cmd_seek, cmd_rw, sector_size_code} = {sk, !sk, n};
    {end_of_track_sector, multi_track_flag, cmd_start} = {e, multi, 1'b1};
    tick(1);
    cmd_start = 1'b0;
    chk(15'(busy_r), 15'h0001);
    if (sk) chk(15'(seek_cyl_r), 15'(target_cylinder));
    else begin
      chk(15'(seek_req_r), 15'(implied_seek_enable));
      if (implied_seek_enable) chk(15'(seek_cyl_r), 15'(cylinder));
      chk(sector_len_r, SECT_BASE_LEN << n);
      chk(xfer_bytes_r, n == 3'h0 ? 15'(short_sector_byte_count) :
          SECT_BASE_LEN << n);
      chk(15'(gap3_len_r), 15'(inter_sector_gap_size));
      chk(15'(mfm_mode_r), 15'(mfm_select));
    end
    {n_sect, hl, xf} = {32'd0, -32'sd1, -32'sd1};
    for (int i = 0; i < 2000 && exec_done_r !== 1'b1; i++) begin
      if (sector_done === 1'b1) n_sect++;
      if (head_load_r === 1'b1 && hl < 0) hl = i;
      if (xfer_active_r === 1'b1 && xf < 0) xf = i;
      tick(1);
    end
    chk(15'(exec_done_r), 15'h0001);
    chk(15'(busy_r), 15'h0000);
  endtask
  initial begin
    {soft_reset, cmd_start, cmd_rw, cmd_seek, multi_track_flag} = '0;
    {spec_write, cfg_write, lock_write, lock_value, perp_write} = '0;
    {perp_gap_select, head_side_select, implied_seek_enable, id_flip} = '0;
    {fifo_enable_low, mfm_select, lat} = {1'b0, 1'b1, 4'h2};
    {cylinder, start_sector, end_of_track_sector, target_cylinder} = '0;
    {inter_sector_gap_size, short_sector_byte_count} = 16'h1bff;
    {precomp_start_track, fifo_threshold, sector_size_code} = 15'h19a8;
    {head_load_delay, head_unload_delay} = {7'h02, 4'h3};
    rst = 1'b1;
    tick(12);
    rst = 1'b0;
    chk(15'(fifo_enable_low_r), 15'(FIFO_EN_LOW_RST));
    chk(15'(lock_r), 15'h0000);
    $display("test 1 done");
    cfg(1'b0);
    chk(15'(fifo_enable_low_r), 15'h0000);
    sreset();
    chk(15'({fifo_enable_low_r, fifo_threshold_r, precomp_track_r}),
        15'h1000);
    {lock_value, lock_write} = 2'h3;
    tick(1);
    lock_write = 1'b0;
    cfg(1'b0);
    sreset();
    chk(15'({fifo_enable_low_r, fifo_threshold_r, precomp_track_r}),
        15'h0533);
    $display("test 2 done");
    spec_write = 1'b1;
    tick(1);
    spec_write = 1'b0;
    target_cylinder = 8'h2a;
    run(1'b1, 3'h0, 8'h00, 1'b0);
    $display("test 3 done");
    cfg(1'b1);
    {cylinder, start_sector} = 16'h1102;
    run(1'b0, 3'h2, 8'h03, 1'b1);
    chk(15'(n_sect), 15'h0005);
    chk(15'({head_sel_r, sector_r}), 15'h0103);
    chk(15'(xf - hl >= U && xf - hl <= 2 * U + 2), 15'h0001);
    tick(6);
    chk(15'(head_load_r), 15'h0001);
    tick(9);
    chk(15'(head_load_r), 15'h0000);
    $display("test 4 done");
    cfg(1'b0);
    {mfm_select, head_side_select, lat} = {1'b0, 1'b1, 4'h9};
    {short_sector_byte_count, start_sector} = 16'h4004;
    run(1'b0, 3'h0, 8'h04, 1'b0);
    chk(15'({head_sel_r, head_match_r, sector_r}), 15'h0304);
    chk(15'(n_sect), 15'h0001);
    $display("test 5 done");
    {head_side_select, start_sector, lat} = {1'b0, 8'h01, 4'h1};
    for (int n = 1; n < 8; n++) begin
      id_flip = n[0];
      run(1'b0, 3'(n), 8'h01, 1'b0);
      chk(15'(n_sect), 15'h0001);
      chk(15'(head_match_r), 15'(!n[0]));
    end
    $display("test 6 done");
    chk(15'(gap2_len_r), 15'(GAP2_STD_LEN));
    {perp_gap_select, perp_write} = 2'h3;
    tick(1);
    perp_write = 1'b0;
    tick(1);
    chk(15'(gap2_len_r), 15'(GAP2_PERP_LEN));
    $display("test 7 done");
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
